// >>> common/psram_host_regs.svh
`ifndef PSRAM_HOST_REGS_SVH
`define PSRAM_HOST_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define LINK_PERIOD_NS 200
`define HALF_CYC ((`LINK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define QTR_CYC (((`HALF_CYC / 2) < 1) ? 1 : (`HALF_CYC / 2))

// ----------------------------------------------------------------------------
// Transaction shape
// ----------------------------------------------------------------------------
`define CMD_HALVES 2
`define ADDR_HALVES 4
`define LATENCY_DEF 6
`define LAT_MULT 2
`define MAX_WORDS_DEF 64
`define RD_SLACK_HALVES 16
`define WR_FIFO_DEPTH 16

`endif

// >>> common/psram_host_pkg.sv
`default_nettype none

package psram_host_pkg;

  typedef enum logic [1:0] {
    OP_CMD_ONLY,
    OP_REG_WRITE,
    OP_ARRAY_WRITE,
    OP_READ
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [15:0] words;
  } req_t;

  typedef struct packed {
    logic [1:0] mask;
    logic [15:0] data;
  } wr_word_t;

endpackage : psram_host_pkg

`default_nettype wire

// >>> logic/octal_psram_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "psram_host_regs.svh"

module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = `WR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic ready_ff, nxt_ready;
  logic push, pop;

  assign push = in_valid && ready_ff;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
    nxt_ready = (nxt_count < (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      ready_ff <= nxt_ready;
    end
  end
endmodule : word_fifo

module octal_psram_host
  import psram_host_pkg::*;
#(
  parameter int LATENCY = `LATENCY_DEF,
  parameter int MAX_WORDS = `MAX_WORDS_DEF,
  parameter int QCYC = `QTR_CYC,
  parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic busy,
  input wire logic wr_valid,
  input wire wr_word_t wr_word,
  output logic wr_ready,
  output logic [15:0] rd_word,
  output logic rd_valid,
  output logic refresh_seen,
  output logic rd_timeout,
  output logic select_n,
  output logic link_clock_out,
  output logic dev_reset_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic strobe_mask_line_in,
  output logic strobe_mask_line_out,
  output logic strobe_mask_line_oe
);
  // --------------------------------------------------------------------------
  // Constants and state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_CMD, ST_ADDR, ST_LAT, ST_WDATA, ST_RDATA, ST_FIN
  } state_t;

  localparam int QW = (QCYC > 1) ? $clog2(QCYC) : 1;
  localparam int LAT_HALVES = 2 * `LAT_MULT * LATENCY;
  localparam int EDGE_GAP = 2 * QCYC;

  state_t state_ff, nxt_state;
  req_t req_ff, nxt_req;
  wr_word_t cur_ff, nxt_cur;
  logic [QW-1:0] qcnt_ff, nxt_qcnt;
  logic phase_ff, nxt_phase;
  logic [16:0] halves_ff, nxt_halves;
  logic [15:0] rx_words_ff, nxt_rx_words;
  logic [7:0] rx_hi_ff, nxt_rx_hi;
  logic rx_half_ff, nxt_rx_half;
  logic cs_n_ff, nxt_cs_n, lclk_ff, nxt_lclk;
  logic [7:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe, sm_ff, nxt_sm, sm_oe_ff, nxt_sm_oe;
  logic ready_ff, nxt_ready, busy_ff, nxt_busy;
  logic [15:0] rd_word_ff, nxt_rd_word;
  logic rd_valid_ff, nxt_rd_valid, refr_ff, nxt_refr, tmo_ff, nxt_tmo;
  logic sm_filt_ff, nxt_sm_filt, dev_rst_ff;
  logic [2:0] sm_sync_ff;
  logic [7:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
  logic qtick, rx_evt, rx_done, fifo_valid, fifo_pop, last_half;
  logic [17:0] fifo_data;
  wr_word_t fifo_word;

  assign qtick = (qcnt_ff == QW'(QCYC - 1));
  assign rx_evt = (sm_sync_ff[1] == sm_sync_ff[2]) &&
                  (sm_sync_ff[2] != sm_filt_ff);
  assign rx_done = (rx_words_ff == req_ff.words);
  assign fifo_word = wr_word_t'(fifo_data);

  // --------------------------------------------------------------------------
  // Write data buffer
  // --------------------------------------------------------------------------
  word_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) wr_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_data(wr_word),
    .in_ready(wr_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_sync_ff <= '0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      dq_s3_ff <= '0;
      dev_rst_ff <= 1'b0;
    end else begin
      sm_sync_ff <= {sm_sync_ff[1:0], strobe_mask_line_in};
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      dev_rst_ff <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Transaction sequencer
  // --------------------------------------------------------------------------
  // Each half link period is two quarter ticks: the first launches the
  // byte, the second toggles the clock, so data sits centred on the edge.
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_cur = cur_ff;
    nxt_qcnt = qtick ? '0 : qcnt_ff + 1'b1;
    nxt_phase = phase_ff;
    nxt_halves = halves_ff;
    nxt_rx_words = rx_words_ff;
    nxt_rx_hi = rx_hi_ff;
    nxt_rx_half = rx_half_ff;
    nxt_cs_n = cs_n_ff;
    nxt_lclk = lclk_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_sm = sm_ff;
    nxt_sm_oe = sm_oe_ff;
    nxt_ready = ready_ff;
    nxt_busy = busy_ff;
    nxt_rd_word = rd_word_ff;
    nxt_rd_valid = 1'b0;
    nxt_refr = refr_ff;
    nxt_tmo = tmo_ff;
    nxt_sm_filt = (sm_sync_ff[1] == sm_sync_ff[2]) ? sm_sync_ff[2] :
                  sm_filt_ff;
    fifo_pop = 1'b0;
    last_half = 1'b0;
    if (state_ff == ST_RDATA && !sm_oe_ff && rx_evt && !rx_done) begin
      if (!rx_half_ff) begin
        nxt_rx_hi = dq_s3_ff;
        nxt_rx_half = 1'b1;
      end else begin
        nxt_rd_word = {rx_hi_ff, dq_s3_ff};
        nxt_rd_valid = 1'b1;
        nxt_rx_half = 1'b0;
        nxt_rx_words = rx_words_ff + 1'b1;
      end
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_qcnt = '0;
        nxt_ready = 1'b1;
        if (req_valid && ready_ff) begin
          nxt_req = req;
          if (req.kind != OP_CMD_ONLY && req.words == '0) begin
            nxt_req.words = 16'h0001;
          end else if (req.words > 16'(MAX_WORDS)) begin
            nxt_req.words = 16'(MAX_WORDS);
          end
          nxt_state = ST_SEL;
          nxt_cs_n = 1'b0;
          nxt_ready = 1'b0;
          nxt_busy = 1'b1;
          nxt_phase = 1'b0;
          nxt_halves = '0;
          nxt_rx_words = '0;
          nxt_rx_half = 1'b0;
          nxt_tmo = 1'b0;
        end
      end
      default: begin
        if (qtick && !phase_ff) begin
          nxt_phase = 1'b1;
          case (state_ff)
            ST_CMD: begin
              nxt_dq = req_ff.opcode;
              nxt_dq_oe = 1'b1;
            end
            ST_ADDR: begin
              nxt_dq = req_ff.addr[8'(31 - 8 * halves_ff[1:0]) -: 8];
              nxt_dq_oe = 1'b1;
            end
            ST_WDATA: begin
              if (!halves_ff[0]) begin
                if (fifo_valid) begin
                  fifo_pop = 1'b1;
                  nxt_cur = fifo_word;
                  nxt_dq = fifo_word.data[15:8];
                  nxt_sm = fifo_word.mask[1];
                end else begin
                  nxt_phase = 1'b0;
                end
              end else begin
                nxt_dq = cur_ff.data[7:0];
                nxt_sm = cur_ff.mask[0];
              end
              nxt_dq_oe = 1'b1;
              nxt_sm_oe = 1'b1;
            end
            default: begin
              nxt_dq_oe = 1'b0;
              nxt_sm_oe = 1'b0;
            end
          endcase
        end else if (qtick) begin
          nxt_phase = 1'b0;
          nxt_halves = halves_ff + 1'b1;
          nxt_lclk = !lclk_ff;
          case (state_ff)
            ST_SEL: begin
              nxt_lclk = lclk_ff;
              nxt_halves = '0;
              nxt_state = ST_CMD;
            end
            ST_CMD: begin
              if (halves_ff == 17'(`CMD_HALVES - 1)) begin
                nxt_halves = '0;
                nxt_state = (req_ff.kind == OP_CMD_ONLY) ? ST_FIN :
                            ST_ADDR;
              end
            end
            ST_ADDR: begin
              if (halves_ff == 17'(`ADDR_HALVES - 1)) begin
                nxt_halves = '0;
                nxt_refr = sm_filt_ff;
                if (req_ff.kind == OP_REG_WRITE) begin
                  nxt_state = ST_WDATA;
                end else begin
                  nxt_state = ST_LAT;
                end
              end
            end
            ST_LAT: begin
              // The refresh flag does not shorten the wait: doubled always.
              if (halves_ff == 17'(LAT_HALVES - 1)) begin
                nxt_halves = '0;
                nxt_state = (req_ff.kind == OP_READ) ? ST_RDATA :
                            ST_WDATA;
              end
            end
            ST_WDATA: begin
              // Halves count from zero, so the last is twice the words less one.
              last_half = (halves_ff == 17'({req_ff.words, 1'b0} - 1'b1));
              if (last_half) begin
                nxt_state = ST_FIN;
              end
            end
            ST_RDATA: begin
              if (rx_done && !lclk_ff) begin
                nxt_lclk = lclk_ff;
                nxt_state = ST_FIN;
              end else if (halves_ff >= 17'({req_ff.words, 1'b0} +
                           17'(`RD_SLACK_HALVES)) && !lclk_ff) begin
                nxt_lclk = lclk_ff;
                nxt_tmo = 1'b1;
                nxt_state = ST_FIN;
              end
            end
            default: begin
              nxt_lclk = lclk_ff;
              nxt_cs_n = 1'b1;
              nxt_dq_oe = 1'b0;
              nxt_sm_oe = 1'b0;
              nxt_busy = 1'b0;
              nxt_ready = 1'b1;
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      cur_ff <= '0;
      qcnt_ff <= '0;
      phase_ff <= 1'b0;
      halves_ff <= '0;
      rx_words_ff <= '0;
      rx_hi_ff <= '0;
      rx_half_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      lclk_ff <= 1'b0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      sm_ff <= 1'b0;
      sm_oe_ff <= 1'b0;
      ready_ff <= 1'b0;
      busy_ff <= 1'b0;
      rd_word_ff <= '0;
      rd_valid_ff <= 1'b0;
      refr_ff <= 1'b0;
      tmo_ff <= 1'b0;
      sm_filt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      cur_ff <= nxt_cur;
      qcnt_ff <= nxt_qcnt;
      phase_ff <= nxt_phase;
      halves_ff <= nxt_halves;
      rx_words_ff <= nxt_rx_words;
      rx_hi_ff <= nxt_rx_hi;
      rx_half_ff <= nxt_rx_half;
      cs_n_ff <= nxt_cs_n;
      lclk_ff <= nxt_lclk;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      sm_ff <= nxt_sm;
      sm_oe_ff <= nxt_sm_oe;
      ready_ff <= nxt_ready;
      busy_ff <= nxt_busy;
      rd_word_ff <= nxt_rd_word;
      rd_valid_ff <= nxt_rd_valid;
      refr_ff <= nxt_refr;
      tmo_ff <= nxt_tmo;
      sm_filt_ff <= nxt_sm_filt;
    end
  end

  assign req_ready = ready_ff;
  assign busy = busy_ff;
  assign rd_word = rd_word_ff;
  assign rd_valid = rd_valid_ff;
  assign refresh_seen = refr_ff;
  assign rd_timeout = tmo_ff;
  assign select_n = cs_n_ff;
  assign link_clock_out = lclk_ff;
  assign dev_reset_n = dev_rst_ff;
  assign dq_out = dq_ff;
  assign dq_oe = dq_oe_ff;
  assign strobe_mask_line_out = sm_ff;
  assign strobe_mask_line_oe = sm_oe_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  state_t prev_state_ff;
  logic lclk_q_ff;
  logic [15:0] lat_cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_state_ff <= ST_IDLE;
      lclk_q_ff <= 1'b0;
      lat_cnt_ff <= '0;
    end else begin
      prev_state_ff <= state_ff;
      lclk_q_ff <= lclk_ff;
      if (state_ff == ST_IDLE) begin
        lat_cnt_ff <= '0;
      end else if (prev_state_ff == ST_LAT && lclk_ff != lclk_q_ff) begin
        lat_cnt_ff <= lat_cnt_ff + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  select_idle_clk_a: assert property ($fell(cs_n_ff) |-> !lclk_ff [*2])
    else $error("select fell while link clock was not idle");
  select_end_a: assert property ($rose(cs_n_ff) |-> !lclk_ff && !dq_oe_ff)
    else $error("select rose with clock high or data driven");
  cmd_repeat_a: assert property ((state_ff == ST_CMD && dq_oe_ff) |->
    dq_ff == req_ff.opcode)
    else $error("command byte differs from opcode");
  addr_msb_a: assert property ((state_ff == ST_ADDR && halves_ff == '0 &&
    phase_ff) |-> dq_ff == req_ff.addr[31:24])
    else $error("first address byte is not the top byte");
  lat_doubled_a: assert property ((prev_state_ff == ST_LAT &&
    state_ff != ST_LAT) |=> lat_cnt_ff == 16'(LAT_HALVES))
    else $error("latency edge count is not the doubled count");
  reg_nolat_a: assert property (($past(state_ff) == ST_ADDR &&
    state_ff != ST_ADDR && req_ff.kind == OP_REG_WRITE) |->
    state_ff == ST_WDATA)
    else $error("register write did not go straight to data");
  array_lat_a: assert property (($past(state_ff) == ST_ADDR &&
    state_ff != ST_ADDR && req_ff.kind != OP_REG_WRITE) |->
    state_ff == ST_LAT)
    else $error("array access skipped its latency");
  lat_clock_runs_a: assert property (state_ff == ST_LAT |->
    ##[1:EDGE_GAP] $changed(lclk_ff))
    else $error("link clock stopped during latency");
  strobe_owner_a: assert property ((state_ff == ST_CMD ||
    state_ff == ST_ADDR || state_ff == ST_LAT) |-> !sm_oe_ff)
    else $error("host drove strobe before the data phase");
  low_byte_a: assert property ((state_ff == ST_WDATA && halves_ff[0] &&
    phase_ff) |-> dq_ff == cur_ff.data[7:0] && sm_ff == cur_ff.mask[0])
    else $error("second byte of a word is not the low byte");
  burst_limit_a: assert property (state_ff != ST_IDLE |->
    req_ff.words <= 16'(MAX_WORDS))
    else $error("burst longer than the limit");
endmodule : octal_psram_host

`default_nettype wire

// >>> testbench/psram_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module psram_dev_model #(
  parameter int LATENCY = 1,
  parameter logic [7:0] OPC_RD = 8'hA0,
  parameter logic [7:0] OPC_WR = 8'hA1,
  parameter logic [7:0] OPC_RG = 8'hA2
) (
  input wire logic clk,
  input wire logic dev_reset_n,
  input wire logic select_n,
  input wire logic link_clock,
  input wire logic [7:0] host_dq,
  input wire logic host_dq_oe,
  input wire logic host_st,
  input wire logic host_st_oe,
  input wire logic refresh_req,
  input wire logic [3:0] slow_halves,
  input wire logic [7:0] stop_words,
  output logic [7:0] dq_pin,
  output logic strobe_pin,
  output logic clash,
  output logic proto_err
);
  logic [7:0] mem [256];
  logic [7:0] reg_bytes [8];
  logic [7:0] dq_drv, dq_last, opc;
  logic [31:0] addr;
  logic dq_en, st_drv, st_en, st_last, clk_prev, in_frame;
  int edges, last_edges, lat, d;

  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3C;
    {dq_last, st_last, clash, proto_err} = '0;
    {dq_en, st_en, st_drv, clk_prev, in_frame} = '0;
    lat = 0;
  end

  // Nothing holds a released line, so it shows the inverse of its last level.
  assign dq_pin = host_dq_oe ? host_dq : (dq_en ? dq_drv : ~dq_last);
  assign strobe_pin = host_st_oe ? host_st : (st_en ? st_drv : ~st_last);

  always @(posedge clk) begin
    dq_last <= (host_dq_oe || dq_en) ? dq_pin : dq_last;
    st_last <= (host_st_oe || st_en) ? strobe_pin : st_last;
    if ((host_dq_oe && dq_en) || (host_st_oe && st_en)) begin
      clash <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Frame decoder, one step per edge of the link clock
  // --------------------------------------------------------------------------
  always @(select_n or link_clock or dev_reset_n) begin
    if (dev_reset_n !== 1'b1) begin
      dq_en = 1'b0;
      st_en = 1'b0;
      in_frame = 1'b0;
    end else if (select_n) begin
      if (in_frame) last_edges = edges;
      in_frame = 1'b0;
      dq_en = 1'b0;
      st_en = 1'b0;
    end else if (!in_frame) begin
      if (link_clock !== 1'b0) proto_err = 1'b1;
      in_frame = 1'b1;
      edges = 0;
      st_en = 1'b1;
      st_drv = refresh_req;
    end else if (link_clock !== clk_prev) begin
      if (edges == 0) opc = dq_pin;
      if (edges == 1 && dq_pin !== opc) proto_err = 1'b1;
      if (edges > 1 && edges < 6) addr = {addr[23:0], dq_pin};
      if (edges == 5) begin
        lat = (opc == OPC_RG) ? 0 : 4 * LATENCY;
        lat = lat + ((opc == OPC_RD) ? int'(slow_halves) : 0);
        st_en = (opc == OPC_RD);
        st_drv = 1'b0;
      end
      d = edges - 6 - lat;
      if (edges > 5 && d >= 0) begin
        if (opc == OPC_RD && (stop_words == 0 || d < 2 * stop_words)) begin
          dq_drv = mem[8'(addr * 2 + d)];
          dq_en = 1'b1;
          st_drv = ~st_drv;
        end else if (opc == OPC_RD) begin
          dq_en = 1'b0;
        end else if (opc == OPC_WR && strobe_pin !== 1'b1) begin
          mem[8'(addr * 2 + d)] = dq_pin;
        end else if (opc == OPC_RG && d < 8) begin
          reg_bytes[d] = dq_pin;
        end
      end
      edges++;
    end
    clk_prev = link_clock;
  end
endmodule : psram_dev_model

`default_nettype wire

// >>> testbench/octal_ddr_psram_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module octal_ddr_psram_interface_tb_top import psram_host_pkg::*;;
  localparam int LAT = 1;
  localparam int LIMIT = 20000;
  localparam logic [7:0] OPC_RD = 8'hA0;
  localparam logic [7:0] OPC_WR = 8'hA1;
  localparam logic [7:0] OPC_RG = 8'hA2;
  localparam logic [7:0] OPC_CM = 8'hA3;

  logic clk, rst_n, req_valid, req_ready, busy, wr_valid, wr_ready;
  logic rd_valid, refresh_seen, rd_timeout, select_n, link_clock;
  logic dev_reset_n, dq_oe, st_in, st_out, st_oe, refresh_req;
  logic clash, proto_err;
  req_t req;
  wr_word_t wr_word;
  logic [15:0] rd_word;
  logic [7:0] dq_in, dq_out, stop_words;
  logic [3:0] slow_halves;
  logic [7:0] exp_mem [256];
  logic [15:0] rd_q [$];
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  octal_psram_host #(.LATENCY(LAT), .MAX_WORDS(20)) DUT (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .busy(busy), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_ready(wr_ready), .rd_word(rd_word),
    .rd_valid(rd_valid), .refresh_seen(refresh_seen),
    .rd_timeout(rd_timeout), .select_n(select_n),
    .link_clock_out(link_clock), .dev_reset_n(dev_reset_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .strobe_mask_line_in(st_in), .strobe_mask_line_out(st_out),
    .strobe_mask_line_oe(st_oe)
  );

  psram_dev_model #(.LATENCY(LAT), .OPC_RD(OPC_RD), .OPC_WR(OPC_WR),
    .OPC_RG(OPC_RG)) dev_model (
    .clk(clk), .dev_reset_n(dev_reset_n), .select_n(select_n),
    .link_clock(link_clock), .host_dq(dq_out), .host_dq_oe(dq_oe),
    .host_st(st_out), .host_st_oe(st_oe), .refresh_req(refresh_req),
    .slow_halves(slow_halves), .stop_words(stop_words), .dq_pin(dq_in),
    .strobe_pin(st_in), .clash(clash), .proto_err(proto_err)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) rd_q.push_back(rd_word);
    if (cyc == LIMIT) begin
      bad_count++;
      $display("CHECK FAILED %0t run too long", $time);
      summarize();
    end
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check

  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Valid is left high between words; the caller lowers it after the last.
  task automatic push(input logic [15:0] w, input logic [1:0] m,
                      input logic [31:0] a);
    wr_word <= '{mask: m, data: w};
    wr_valid <= 1'b1;
    do @(posedge clk); while (wr_ready !== 1'b1);
    if (!m[1]) exp_mem[8'(2 * a)] = w[15:8];
    if (!m[0]) exp_mem[8'(2 * a + 1)] = w[7:0];
  endtask : push

  task automatic do_req(input op_kind_t k, input logic [7:0] o,
                        input logic [31:0] a, input logic [15:0] n);
    req <= '{kind: k, opcode: o, addr: a, words: n};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    check(busy === 1'b1 && select_n === 1'b0, "select low");
    do @(posedge clk); while (req_ready !== 1'b1);
    check(busy === 1'b0 && select_n === 1'b1, "select high");
  endtask : do_req

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] n,
                        input int exp_n, input logic exp_to);
    rd_q.delete();
    do_req(OP_READ, OPC_RD, a, n);
    check(rd_q.size() == exp_n, "read word count");
    for (int i = 0; i < rd_q.size() && i < exp_n; i++)
      check(rd_q[i] === {exp_mem[8'(2 * a + 2 * i)],
                         exp_mem[8'(2 * a + 2 * i + 1)]}, "read data");
    check(rd_timeout === exp_to, "read timeout flag");
  endtask : rd_chk

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic masked_write();
    logic [15:0] w [4] = '{16'h1122, 16'h3344, 16'h5566, 16'h7788};
    refresh_req <= 1'b1;
    for (int i = 0; i < 4; i++)
      push(w[i], 2'(i), 32'(2 + i));
    wr_valid <= 1'b0;
    do_req(OP_ARRAY_WRITE, OPC_WR, 32'h2, 16'h4);
    check(refresh_seen === 1'b1, "refresh seen");
    check(dev_model.last_edges == 6 + 4 * LAT + 8, "write edges");
    refresh_req <= 1'b0;
    rd_chk(32'h2, 16'h4, 4, 1'b0);
    check(refresh_seen === 1'b0, "no refresh");
  endtask : masked_write

  task automatic reg_and_cmd();
    push(16'hC3A5, 2'b00, 32'hF0);
    push(16'h5A0F, 2'b00, 32'hF1);
    wr_valid <= 1'b0;
    exp_mem[8'hE0] = 8'hE0 ^ 8'h3C;
    exp_mem[8'hE1] = 8'hE1 ^ 8'h3C;
    exp_mem[8'hE2] = 8'hE2 ^ 8'h3C;
    exp_mem[8'hE3] = 8'hE3 ^ 8'h3C;
    do_req(OP_REG_WRITE, OPC_RG, 32'h4, 16'h2);
    check(dev_model.last_edges == 10, "register write edges");
    check({dev_model.reg_bytes[0], dev_model.reg_bytes[1],
           dev_model.reg_bytes[2], dev_model.reg_bytes[3]} === 32'hC3A55A0F,
          "register data");
    do_req(OP_CMD_ONLY, OPC_CM, 32'h0, 16'h0);
    check(dev_model.last_edges == 2 && dev_model.opc === OPC_CM,
          "command only");
  endtask : reg_and_cmd

  task automatic fifo_burst();
    for (int i = 0; i < 16; i++)
      push(16'hA500 + 16'(i), 2'b00, 32'(40 + i));
    wr_valid <= 1'b0;
    repeat (2) @(posedge clk);
    check(wr_ready === 1'b0, "full buffer refuses");
    fork
      do_req(OP_ARRAY_WRITE, OPC_WR, 32'h28, 16'h14);
      begin
        repeat (250) @(posedge clk);
        for (int i = 16; i < 20; i++)
          push(16'hA500 + 16'(i), 2'b00, 32'(40 + i));
        wr_valid <= 1'b0;
      end
    join
    check(dev_model.last_edges == 50, "stalled burst edges");
    rd_chk(32'h28, 16'h18, 20, 1'b0);
  endtask : fifo_burst

  task automatic odd_reads();
    slow_halves <= 4'h6;
    rd_chk(32'h2, 16'h2, 2, 1'b0);
    slow_halves <= 4'h0;
    stop_words <= 8'h01;
    rd_chk(32'h28, 16'h3, 1, 1'b1);
    stop_words <= 8'h00;
    rd_chk(32'h2A, 16'h0, 1, 1'b0);
  endtask : odd_reads

  initial begin
    for (int i = 0; i < 256; i++)
      exp_mem[i] = 8'(i) ^ 8'h3C;
    rst_n <= 1'b0;
    req_valid <= 1'b0;
    req <= '0;
    wr_valid <= 1'b0;
    wr_word <= '0;
    refresh_req <= 1'b0;
    slow_halves <= 4'h0;
    stop_words <= 8'h00;
    @(posedge clk);
    #1;
    check(select_n === 1'b1 && req_ready === 1'b0, "idle in reset");
    check(dq_oe === 1'b0 && st_oe === 1'b0 && dev_reset_n === 1'b0,
          "reset pins");
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(req_ready === 1'b1 && dev_reset_n === 1'b1, "ready");
    masked_write();
    reg_and_cmd();
    fifo_burst();
    odd_reads();
    check(proto_err === 1'b0, "link framing");
    check(clash === 1'b0, "no bus fight");
    summarize();
  end
endmodule : octal_ddr_psram_interface_tb_top

`default_nettype wire
